/* rtl/icache_map.vh */
// register map, field positions, reset values and fixed sizes of the instruction cache
`ifndef ICACHE_MAP_VH
`define ICACHE_MAP_VH

// register byte offsets on the spoke
`define REG_CACHE_CONTROL 4'h0
`define REG_HIT_MISS_COUNTERS 4'h4
`define REG_SINGLE_ERROR_LOG 4'h8
`define REG_UNCORR_ERROR_LOG 4'hC

// spoke address windows
`define HUB_FLASH_BIT 29
`define HUB_RAM_BIT 7

// cache_control fields
`define CTL_DISABLE_BIT 0
`define CTL_SLEEP_BIT 1
`define CTL_INVALIDATE_BIT 2
`define CTL_THR_LSB 8

// hit_miss_counters fields
`define HM_HIT_LSB 16
`define HM_MISS_LSB 0

// error log fields
`define LOG_VALID_BIT 29
`define LOG_IRQ_EN_BIT 30

// reset values
`define CTL_DISABLE_RST 1'b0
`define CTL_THR_RST 8'h10

// geometry: 16 lines of 8 bytes = 128 bytes
`define LINE_BYTES 8
`define CACHE_BYTES 128

`endif

/* rtl/cache_ram.v */
// single-port cache line memory with bit write mask and registered read data
`timescale 1ns/10ps
`default_nettype none
module cache_ram #(
    parameter ADDR_W = 4,
    parameter DATA_W = 86
) (
    input wire clk_i,
    input wire we_i,
    input wire [ADDR_W-1:0] addr_i,
    input wire [DATA_W-1:0] wmask_i,
    input wire [DATA_W-1:0] wdata_i,
    output reg [DATA_W-1:0] rdata_o
);
    reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // masked write, read data from a register
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= (mem[addr_i] & ~wmask_i) | (wdata_i & wmask_i);
        end
        rdata_o <= mem[addr_i];
    end
endmodule // cache_ram
`default_nettype wire

/* rtl/icache_ctrl.v */
// direct-mapped instruction cache controller between cpu fetch port, flash and hub spoke
`timescale 1ns/10ps
`default_nettype none
`include "icache_map.vh"
module icache_ctrl #(
    parameter FA_W = 29,
    parameter IDX_W = 4,
    parameter THR_W = 8,
    parameter CNT_W = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire wake_i,
    input wire fetch_req_i,
    input wire [FA_W-1:0] fetch_addr_i,
    output reg fetch_ack_o,
    output reg [31:0] fetch_data_o,
    output reg flash_req_o,
    output reg [FA_W-1:0] flash_addr_o,
    input wire flash_ack_i,
    input wire [63:0] flash_data_i,
    input wire single_error_log_i,
    input wire ecc_fail_i,
    output reg flash_sleep_o,
    input wire hub_req_i,
    input wire hub_wr_i,
    input wire [29:0] hub_addr_i,
    input wire [31:0] hub_wdata_i,
    output reg hub_ack_o,
    output reg [31:0] hub_rdata_o,
    output reg ecc_irq_o
);
    localparam LINES = 1 << IDX_W;
    localparam TAG_W = FA_W - IDX_W - 3;
    localparam ROW_W = TAG_W + 64;
    localparam [4:0] S_IDLE = 5'b00001;
    localparam [4:0] S_LOOK = 5'b00010;
    localparam [4:0] S_FILL = 5'b00100;
    localparam [4:0] S_HRAM = 5'b01000;
    localparam [4:0] S_HFL = 5'b10000;

    // one word of a two-word line
    function [31:0] pick_word;
        input [63:0] line;
        input sel;
        begin
            pick_word = sel ? line[63:32] : line[31:0];
        end
    endfunction

    // line index of a byte address
    function [IDX_W-1:0] line_of;
        input [FA_W-1:0] addr;
        begin
            line_of = addr[IDX_W+2:3];
        end
    endfunction

    // 8-byte aligned flash line address of a byte address
    function [FA_W-1:0] line_base;
        input [FA_W-1:0] addr;
        begin
            line_base = {addr[FA_W-1:3], 3'b000};
        end
    endfunction

    // fsm state and the request being served
    reg [4:0] state_q;
    reg [FA_W-1:0] addr_q;
    reg [29:0] hub_addr_q;

    // line valid bits, hit run counter and software-visible state
    reg [LINES-1:0] valid_q;
    reg disable_q;
    reg [THR_W-1:0] thr_q;
    reg [CNT_W-1:0] hit_cnt_q;
    reg [CNT_W-1:0] miss_cnt_q;
    reg [THR_W-1:0] seq_q;
    reg [FA_W-1:0] corr_addr_q;
    reg corr_valid_q;
    reg corr_irq_en_q;
    reg [FA_W-1:0] fail_addr_q;
    reg fail_valid_q;

    // cache RAM port, driven by the mux below
    reg ram_we;
    reg [IDX_W-1:0] ram_addr;
    reg [ROW_W-1:0] ram_wmask;
    reg [ROW_W-1:0] ram_wdata;
    wire [ROW_W-1:0] ram_rdata;

    // lookup fields of the captured fetch and request acceptance
    wire [IDX_W-1:0] idx_q = line_of(addr_q);
    wire [TAG_W-1:0] tag_q = addr_q[FA_W-1:IDX_W+3];
    wire idle_free = (state_q == S_IDLE) && !fetch_ack_o && !hub_ack_o;
    wire take_fetch = idle_free && fetch_req_i;
    wire take_hub = idle_free && !fetch_req_i && hub_req_i;

    // spoke window decode: flash, cache RAM, registers
    wire hub_fl = hub_addr_i[`HUB_FLASH_BIT];
    wire hub_ram = !hub_fl && hub_addr_i[`HUB_RAM_BIT] && (hub_addr_i[28:8] == 21'h000000);
    wire hub_reg = !hub_fl && (hub_addr_i[28:4] == 25'h0000000);
    wire reg_wr = take_hub && hub_wr_i && hub_reg;
    wire ctl_wr = reg_wr && (hub_addr_i[3:0] == `REG_CACHE_CONTROL);
    wire hm_wr = reg_wr && (hub_addr_i[3:0] == `REG_HIT_MISS_COUNTERS);
    wire corr_wr = reg_wr && (hub_addr_i[3:0] == `REG_SINGLE_ERROR_LOG);
    wire fail_wr = reg_wr && (hub_addr_i[3:0] == `REG_UNCORR_ERROR_LOG);

    // invalidate, lookup result and fill qualifiers
    wire inv_all = (ctl_wr && hub_wdata_i[`CTL_INVALIDATE_BIT]) || wake_i;
    wire hit = valid_q[idx_q] && (ram_rdata[ROW_W-1:64] == tag_q);
    wire fill_done = (state_q == S_FILL) && flash_ack_i;
    wire fill_ok = fill_done && !disable_q && !ecc_fail_i;
    wire hub_flash_rd = take_hub && hub_fl && !hub_wr_i; // ignored flash-window writes leave the flash asleep
    wire start_flash = (take_fetch && disable_q) || ((state_q == S_LOOK) && !hit) || hub_flash_rd;

    // cache RAM port: lookup read, fill write, spoke word access
    always @* begin
        ram_we = 1'b0;
        ram_addr = idx_q;
        ram_wmask = {ROW_W{1'b0}};
        ram_wdata = {ROW_W{1'b0}};
        if (take_fetch) begin
            ram_addr = line_of(fetch_addr_i);
        end else if (fill_ok) begin
            ram_we = 1'b1;
            ram_wmask = {ROW_W{1'b1}};
            ram_wdata = {tag_q, flash_data_i};
        end else if (take_hub && hub_ram) begin
            ram_addr = line_of(hub_addr_i[FA_W-1:0]);
            ram_we = hub_wr_i;
            ram_wmask = hub_addr_i[2] ? {{TAG_W{1'b0}}, 32'hFFFFFFFF, 32'h00000000}
                                      : {{TAG_W{1'b0}}, 32'h00000000, 32'hFFFFFFFF};
            ram_wdata = {{TAG_W{1'b0}}, hub_wdata_i, hub_wdata_i};
        end
    end

    cache_ram #(
        .ADDR_W(IDX_W),
        .DATA_W(ROW_W)
    ) u_ram (
        .clk_i(clk_i),
        .we_i(ram_we),
        .addr_i(ram_addr),
        .wmask_i(ram_wmask),
        .wdata_i(ram_wdata),
        .rdata_o(ram_rdata)
    );

    // control state machine
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
            addr_q <= {FA_W{1'b0}};
            hub_addr_q <= 30'h00000000;
            fetch_ack_o <= 1'b0;
            fetch_data_o <= 32'h00000000;
            flash_req_o <= 1'b0;
            flash_addr_o <= {FA_W{1'b0}};
            hub_ack_o <= 1'b0;
            hub_rdata_o <= 32'h00000000;
        end else begin
            fetch_ack_o <= 1'b0;
            hub_ack_o <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (take_fetch) begin
                        addr_q <= fetch_addr_i;
                        if (disable_q) begin
                            flash_req_o <= 1'b1;
                            flash_addr_o <= line_base(fetch_addr_i);
                            state_q <= S_FILL;
                        end else begin
                            state_q <= S_LOOK;
                        end
                    end else if (take_hub) begin
                        hub_addr_q <= hub_addr_i;
                        if (hub_fl) begin
                            if (hub_wr_i) begin
                                hub_ack_o <= 1'b1;
                            end else begin
                                flash_req_o <= 1'b1;
                                flash_addr_o <= line_base(hub_addr_i[FA_W-1:0]);
                                state_q <= S_HFL;
                            end
                        end else if (hub_ram) begin
                            state_q <= S_HRAM;
                        end else begin
                            hub_ack_o <= 1'b1;
                            hub_rdata_o <= 32'h00000000;
                            if (hub_reg) begin
                                case (hub_addr_i[3:0])
                                    `REG_CACHE_CONTROL: begin
                                        hub_rdata_o[`CTL_DISABLE_BIT] <= disable_q;
                                        hub_rdata_o[`CTL_SLEEP_BIT] <= flash_sleep_o;
                                        hub_rdata_o[`CTL_THR_LSB+THR_W-1:`CTL_THR_LSB] <= thr_q;
                                    end
                                    `REG_HIT_MISS_COUNTERS: begin
                                        hub_rdata_o <= {hit_cnt_q, miss_cnt_q};
                                    end
                                    `REG_SINGLE_ERROR_LOG: begin
                                        hub_rdata_o[FA_W-1:0] <= corr_addr_q;
                                        hub_rdata_o[`LOG_VALID_BIT] <= corr_valid_q;
                                        hub_rdata_o[`LOG_IRQ_EN_BIT] <= corr_irq_en_q;
                                    end
                                    `REG_UNCORR_ERROR_LOG: begin
                                        hub_rdata_o[FA_W-1:0] <= fail_addr_q;
                                        hub_rdata_o[`LOG_VALID_BIT] <= fail_valid_q;
                                    end
                                    default: begin
                                        hub_rdata_o <= 32'h00000000;
                                    end
                                endcase
                            end
                        end
                    end
                end
                // tag row of the fetch now stands in the RAM output register
                S_LOOK: begin
                    if (hit) begin
                        fetch_ack_o <= 1'b1;
                        fetch_data_o <= pick_word(ram_rdata[63:0], addr_q[2]);
                        state_q <= S_IDLE;
                    end else begin
                        flash_req_o <= 1'b1;
                        flash_addr_o <= line_base(addr_q);
                        state_q <= S_FILL;
                    end
                end
                // wait for the single flash answer of this miss or disabled-cache fetch
                S_FILL: begin
                    if (flash_ack_i) begin
                        flash_req_o <= 1'b0;
                        fetch_ack_o <= 1'b1;
                        fetch_data_o <= pick_word(flash_data_i, addr_q[2]);
                        state_q <= S_IDLE;
                    end
                end
                S_HRAM: begin
                    hub_ack_o <= 1'b1;
                    hub_rdata_o <= pick_word(ram_rdata[63:0], hub_addr_q[2]);
                    state_q <= S_IDLE;
                end
                S_HFL: begin
                    if (flash_ack_i) begin
                        flash_req_o <= 1'b0;
                        hub_ack_o <= 1'b1;
                        hub_rdata_o <= pick_word(flash_data_i, hub_addr_q[2]);
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // line valid bits: invalidate beats fill, failed fill drops the line
    always @(posedge clk_i) begin
        if (rst_i) begin
            valid_q <= {LINES{1'b0}};
        end else if (inv_all) begin
            valid_q <= {LINES{1'b0}};
        end else if (fill_done && !disable_q) begin
            valid_q[idx_q] <= !ecc_fail_i;
        end
    end

    // control register, unaffected by wake
    always @(posedge clk_i) begin
        if (rst_i) begin
            disable_q <= `CTL_DISABLE_RST;
            thr_q <= `CTL_THR_RST;
        end else if (ctl_wr) begin
            disable_q <= hub_wdata_i[`CTL_DISABLE_BIT];
            thr_q <= hub_wdata_i[`CTL_THR_LSB+THR_W-1:`CTL_THR_LSB];
        end
    end

    // hit and miss counters, spoke write loads them
    always @(posedge clk_i) begin
        if (rst_i) begin
            hit_cnt_q <= {CNT_W{1'b0}};
            miss_cnt_q <= {CNT_W{1'b0}};
        end else if (hm_wr) begin
            hit_cnt_q <= hub_wdata_i[`HM_HIT_LSB+CNT_W-1:`HM_HIT_LSB];
            miss_cnt_q <= hub_wdata_i[`HM_MISS_LSB+CNT_W-1:`HM_MISS_LSB];
        end else if (state_q == S_LOOK) begin
            if (hit) begin
                hit_cnt_q <= hit_cnt_q + 1'b1;
            end else begin
                miss_cnt_q <= miss_cnt_q + 1'b1;
            end
        end
    end

    // flash sleep after a run of sequential hits, woken by any flash access
    always @(posedge clk_i) begin
        if (rst_i) begin
            seq_q <= {THR_W{1'b0}};
            flash_sleep_o <= 1'b0;
        end else if (start_flash) begin
            seq_q <= {THR_W{1'b0}};
            flash_sleep_o <= 1'b0;
        end else begin
            if ((state_q == S_LOOK) && hit && (seq_q != {THR_W{1'b1}})) begin
                seq_q <= seq_q + 1'b1;
            end
            if ((state_q == S_IDLE) && (seq_q >= thr_q)) begin
                flash_sleep_o <= 1'b1;
            end
        end
    end

    // ecc logs: hardware set wins over software clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            corr_addr_q <= {FA_W{1'b0}};
            corr_valid_q <= 1'b0;
            corr_irq_en_q <= 1'b0;
            fail_addr_q <= {FA_W{1'b0}};
            fail_valid_q <= 1'b0;
            ecc_irq_o <= 1'b0;
        end else begin
            ecc_irq_o <= fill_done && single_error_log_i && corr_irq_en_q;
            if (corr_wr) begin
                corr_irq_en_q <= hub_wdata_i[`LOG_IRQ_EN_BIT];
                if (hub_wdata_i[`LOG_VALID_BIT]) begin
                    corr_valid_q <= 1'b0;
                end
            end
            if (fail_wr && hub_wdata_i[`LOG_VALID_BIT]) begin
                fail_valid_q <= 1'b0;
            end
            if (fill_done && single_error_log_i) begin
                corr_addr_q <= addr_q;
                corr_valid_q <= 1'b1;
            end
            if (fill_done && ecc_fail_i) begin
                fail_addr_q <= addr_q;
                fail_valid_q <= 1'b1;
            end
        end
    end
endmodule // icache_ctrl
`default_nettype wire

/* verification/icache_ctrl_monitor.sv */
// port assertions for the instruction cache controller
`timescale 1ns/10ps
`default_nettype none
module icache_ctrl_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wake_i,
    input wire logic fetch_ack_o,
    input wire logic flash_req_o,
    input wire logic flash_ack_i,
    input wire logic single_error_log_i,
    input wire logic flash_sleep_o,
    input wire logic hub_req_i,
    input wire logic hub_wr_i,
    input wire logic [29:0] hub_addr_i,
    input wire logic [31:0] hub_wdata_i,
    input wire logic hub_ack_o,
    input wire logic ecc_irq_o
);
    logic dis_q, en_q, cold_q, wr;
    assign wr = hub_ack_o && hub_req_i && hub_wr_i;
    // shadow of spoke-written control bits, cold flag until the next fetch answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dis_q <= 1'h0;
            en_q <= 1'h0;
            cold_q <= 1'h1;
        end else begin
            if (wr && hub_addr_i == 30'h0) dis_q <= hub_wdata_i[0];
            if (wr && hub_addr_i == 30'h8) en_q <= hub_wdata_i[30];
            if (wake_i || (wr && hub_addr_i == 30'h0 && hub_wdata_i[2])) cold_q <= 1'h1;
            else if (fetch_ack_o) cold_q <= 1'h0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_RST_IDLE: assert property ($fell(rst_i) |-> !fetch_ack_o && !flash_req_o && !hub_ack_o && !flash_sleep_o)
        else $error("outputs active right after reset");
    AST_COLD_MISS: assert property (fetch_ack_o && cold_q |-> $past(flash_ack_i))
        else $error("fetch answered from an invalidated cache");
    AST_DIS_MISS: assert property (fetch_ack_o && dis_q |-> $past(flash_ack_i))
        else $error("disabled cache answered without flash");
    AST_ONE_FETCH: assert property (flash_req_o && flash_ack_i |=> !flash_req_o [*2])
        else $error("flash request rose again too soon");
    AST_FILL_ANS: assert property (flash_req_o && flash_ack_i |=> fetch_ack_o || hub_ack_o)
        else $error("flash answer not passed on next cycle");
    AST_IRQ_SET: assert property (flash_req_o && flash_ack_i && single_error_log_i && en_q |=> ecc_irq_o == fetch_ack_o)
        else $error("interrupt does not follow a corrected fill");
    AST_IRQ_CAUSE: assert property (ecc_irq_o |-> en_q && fetch_ack_o && $past(single_error_log_i && flash_ack_i))
        else $error("interrupt without correction");
    AST_SLEEP_WAKE: assert property (flash_req_o && flash_ack_i |-> !flash_sleep_o)
        else $error("flash asleep during a read");
    AST_ACK_PULSE: assert property (fetch_ack_o |=> !fetch_ack_o)
        else $error("fetch answer longer than one cycle");
endmodule // icache_ctrl_monitor
`default_nettype wire

/* verification/flash_model.sv */
// flash stand-in answering line reads with programmable latency
`timescale 1ns/10ps
`default_nettype none
module flash_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic [28:0] addr_i,
    input wire logic [1:0] delay_i,
    input wire logic corr_i,
    input wire logic fail_i,
    output logic ack_o,
    output logic [63:0] data_o,
    output logic corr_o,
    output logic fail_o
);
    logic [1:0] cnt_q;
    logic busy_q;
    logic [63:0] line;
    // two words patterned from the line address, inverse outside the answer cycle
    assign line = {3'h5, addr_i[28:3], 1'h1, 2'h3, 3'h5, addr_i[28:3], 1'h0, 2'h3};
    assign data_o = ack_o ? line : ~line;
    assign corr_o = ack_o & corr_i;
    assign fail_o = ack_o & fail_i;
    // one read outstanding, answered 1 to 4 cycles after it is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'h0;
            ack_o <= 1'h0;
            cnt_q <= 2'h0;
        end else begin
            ack_o <= 1'h0;
            if (req_i && !busy_q && !ack_o) begin
                busy_q <= 1'h1;
                cnt_q <= delay_i;
            end else if (busy_q && cnt_q == 2'h0) begin
                busy_q <= 1'h0;
                ack_o <= 1'h1;
            end else if (busy_q) cnt_q <= cnt_q - 2'h1;
        end
    end
endmodule // flash_model
`default_nettype wire

/* verification/tb_instruction_cache_controller.sv */
// self-checking bench for the instruction cache controller
`timescale 1ns/10ps
`default_nettype none
module tb_instruction_cache_controller;
    logic clk_i = 1'h0, rst_i = 1'h1, wake_i = 1'h0, fetch_req_i = 1'h0, hub_req_i = 1'h0, hub_wr_i = 1'h0;
    logic [28:0] fetch_addr_i = 29'h0;
    logic [29:0] hub_addr_i = 30'h0;
    logic [31:0] hub_wdata_i = 32'h0;
    logic [1:0] dly = 2'h0;
    logic corr = 1'h0, fail = 1'h0, dis = 1'h0;
    logic fetch_ack_o, flash_req_o, flash_ack_i, single_error_log_i, ecc_fail_i, flash_sleep_o, hub_ack_o, ecc_irq_o;
    logic [31:0] fetch_data_o, hub_rdata_o, rd;
    logic [28:0] flash_addr_o, a;
    logic [63:0] flash_data_i;
    logic [21:0] tg [16];
    logic [15:0] vld = 16'h0, hits = 16'h0, misses = 16'h0;
    int errors = 0, checked = 0, irqs = 0, cyc = 0;
    icache_ctrl dut_u (.clk_i, .rst_i, .wake_i, .fetch_req_i, .fetch_addr_i, .fetch_ack_o, .fetch_data_o,
        .flash_req_o, .flash_addr_o, .flash_ack_i, .flash_data_i, .single_error_log_i, .ecc_fail_i, .flash_sleep_o,
        .hub_req_i, .hub_wr_i, .hub_addr_i, .hub_wdata_i, .hub_ack_o, .hub_rdata_o, .ecc_irq_o);
    flash_model flash_u (.clk_i, .rst_i, .req_i(flash_req_o), .addr_i(flash_addr_o), .delay_i(dly), .corr_i(corr),
        .fail_i(fail), .ack_o(flash_ack_i), .data_o(flash_data_i), .corr_o(single_error_log_i), .fail_o(ecc_fail_i));
    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;
    // cycle ceiling and interrupt pulse count
    always @(posedge clk_i) begin
        cyc++;
        if (ecc_irq_o === 1'h1) irqs++;
        if (cyc == 20000) begin
            errors++;
            $display("MISMATCH %0t cycle limit reached", $time);
            close_out();
        end
    end
    function automatic logic [31:0] fw(input logic [28:0] x);
        return {3'h5, x[28:2], 2'h3};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one spoke access held until acknowledged, read data kept in rd
    task automatic hub(input logic w, input logic [29:0] ad, input logic [31:0] wd);
        int n;
        @(posedge clk_i) #1;
        {hub_wr_i, hub_addr_i, hub_wdata_i, hub_req_i} = {w, ad, wd, 1'h1};
        for (n = 0; n < 40 && hub_ack_o !== 1'h1; n++) @(posedge clk_i);
        chk({31'h0, hub_ack_o}, 32'h1);
        rd = hub_rdata_o;
        #1 hub_req_i = 1'h0;
    endtask
    // one fetch with a chosen flash answer, then the expected cache state moves on
    task automatic fx(input logic [28:0] x, input logic c, input logic f);
        int n;
        logic hit;
        hit = !dis && vld[x[6:3]] && tg[x[6:3]] == x[28:7];
        {corr, fail, dly} = {c, f, 2'($urandom_range(3))};
        @(posedge clk_i) #1;
        {fetch_addr_i, fetch_req_i} = {x, 1'h1};
        for (n = 0; n < 40 && fetch_ack_o !== 1'h1; n++) @(posedge clk_i);
        chk({31'h0, fetch_ack_o}, 32'h1);
        chk(fetch_data_o, fw(x));
        #1 fetch_req_i = 1'h0;
        if (!dis && hit) hits++;
        else if (!dis) begin
            misses++;
            vld[x[6:3]] = !f;
            tg[x[6:3]] = x[28:7];
        end
    endtask
    task automatic cnt_chk;
        hub(1'h0, 30'h4, 32'h0);
        chk(rd, {hits, misses});
    endtask
    // main sequence
    initial begin
        void'($urandom(32'h9EC2));
        repeat (4) @(posedge clk_i);
        #1 rst_i = 1'h0;
        for (int i = 0; i < 5; i++) begin
            hub(1'h0, 30'(4 * i), 32'h0);
            chk(rd, i == 0 ? 32'h0000_1000 : 32'h0);
        end
        hub(1'h1, 30'h4, 32'h0);
        for (int i = 0; i < 60; i++) begin
            a = 29'($urandom & 32'h1FC);
            fx(a, 1'h0, 1'h0);
        end
        cnt_chk();
        hub(1'h0, {22'h0, 1'h1, a[6:2], 2'h0}, 32'h0);
        chk(rd, fw(a));
        // spoke write into cache RAM, read back, then the line word put back and fetched as a hit
        hub(1'h1, {22'h0, 1'h1, a[6:2], 2'h0}, 32'h5A5A_0F0F);
        hub(1'h0, {22'h0, 1'h1, a[6:2], 2'h0}, 32'h0);
        chk(rd, 32'h5A5A_0F0F);
        hub(1'h1, {22'h0, 1'h1, a[6:2], 2'h0}, fw(a));
        fx(a, 1'h0, 1'h0);
        a = 29'h1000;
        hub(1'h0, {1'h1, a}, 32'h0);
        chk(rd, fw(a));
        fx(a, 1'h0, 1'h0);
        cnt_chk();
        // corrected fill with interrupt enabled, then a failed fill
        hub(1'h1, 30'h8, 32'h4000_0000);
        a = 29'h2008;
        fx(a, 1'h1, 1'h0);
        hub(1'h0, 30'h8, 32'h0);
        chk(rd, {3'h3, a});
        chk(32'(irqs), 32'h1);
        a = 29'h3010;
        fx(a, 1'h0, 1'h1);
        hub(1'h0, 30'hC, 32'h0);
        chk(rd, {3'h1, a});
        // write one to the valid flags clears them, addresses and enable kept
        hub(1'h1, 30'h8, 32'h6000_0000);
        hub(1'h1, 30'hC, 32'h2000_0000);
        hub(1'h0, 30'h8, 32'h0);
        chk(rd, 32'h4000_2008);
        hub(1'h0, 30'hC, 32'h0);
        chk(rd, {3'h0, a});
        fx(a, 1'h0, 1'h0);
        cnt_chk();
        // disabled cache bypasses lookup and counters
        hub(1'h1, 30'h0, 32'h0000_1001);
        dis = 1'h1;
        fx(a, 1'h0, 1'h0);
        fx(a, 1'h0, 1'h0);
        hub(1'h1, 30'h0, 32'h0000_1000);
        dis = 1'h0;
        fx(a, 1'h0, 1'h0);
        cnt_chk();
        // invalidate by control write and by wake, settings kept
        hub(1'h1, 30'h0, 32'h0000_1004);
        vld = 16'h0;
        fx(a, 1'h0, 1'h0);
        @(posedge clk_i) #1 wake_i = 1'h1;
        @(posedge clk_i) #1 wake_i = 1'h0;
        vld = 16'h0;
        fx(a, 1'h0, 1'h0);
        hub(1'h0, 30'h0, 32'h0);
        chk(rd, 32'h0000_1000);
        cnt_chk();
        // sleep after three straight hits, awake after a miss, threshold zero
        hub(1'h1, 30'h0, 32'h0000_0300);
        for (int i = 0; i < 3; i++) begin
            fx(a, 1'h0, 1'h0);
            repeat (3) @(posedge clk_i);
            chk({31'h0, flash_sleep_o}, {31'h0, i == 2});
        end
        fx(29'h1800, 1'h0, 1'h0);
        chk({31'h0, flash_sleep_o}, 32'h0);
        hub(1'h1, 30'h0, 32'h0);
        repeat (3) @(posedge clk_i);
        chk({31'h0, flash_sleep_o}, 32'h1);
        close_out();
    end
endmodule // tb_instruction_cache_controller
bind icache_ctrl icache_ctrl_monitor mon_u (.clk_i, .rst_i, .wake_i, .fetch_ack_o, .flash_req_o, .flash_ack_i,
    .single_error_log_i, .flash_sleep_o, .hub_req_i, .hub_wr_i, .hub_addr_i, .hub_wdata_i, .hub_ack_o, .ecc_irq_o);
`default_nettype wire
